// ### logic/hole_decode_cfg.svh
// Constants for the legacy hole and low I/O hole decoder.
// Assumes inclusion by the package and the decoder files.
`ifndef HOLE_DECODE_CFG_SVH
`define HOLE_DECODE_CFG_SVH
`define BIOS_LO 32'h000C_0000
`define BIOS_HI 32'h000F_FFFF
`define DISP_MEM_LO 32'h000A_0000
`define DISP_MEM_HI 32'h000B_FFFF
`define DISP_IO_LO 10'h3B0
`define DISP_IO_HI 10'h3DF
`define CFG_LO 32'hFED0_0000
`define CFG_HI 32'hFEDF_FFFF
`define INTMSG_LO 32'hFEE0_0000
`define INTMSG_HI 32'hFEEF_FFFF
`define FW_LO 32'hFF00_0000
`define GUEST_CFG_SIZE 32'h0002_0000
`define GUEST_SLICE_LSB 13
`define FW_SMALL_MAX 7'h10
`define ADDR_A_BIOS_WP 8'h00
`define ADDR_A_DISP 8'h04
`define ADDR_A_DIST_LO 8'h08
`define ADDR_A_DIST_HI 8'h0C
`define ADDR_A_DIST_LSB 8'h10
`define ADDR_A_DIR0_LO 8'h14
`define ADDR_A_DIR0_HI 8'h18
`define ADDR_A_DIR0_ROPE 8'h1C
`define ADDR_A_DIR1_LO 8'h20
`define ADDR_A_DIR1_HI 8'h24
`define ADDR_A_DIR1_ROPE 8'h28
`define ADDR_A_WIDE 8'h2C
`define ADDR_A_GCFG 8'h30
`define ADDR_A_FWHUB 8'h34
`define ADDR_A_STATUS 8'h38
`endif

// ### logic/hole_decode_pkg.sv
// Types for the hole decoder.
// Assumes the cfg header is on the include path.
`include "hole_decode_cfg.svh"
package hole_decode_pkg;
	typedef enum logic [7:0] {
		TGT_NONE = 8'h01,
		TGT_MEM = 8'h02,
		TGT_ROPE = 8'h04,
		TGT_CFG = 8'h08,
		TGT_GUEST_CFG = 8'h10,
		TGT_FW_HUB = 8'h20,
		TGT_DROP = 8'h40,
		TGT_REJECT = 8'h80
	} target_t;
endpackage

// ### logic/range_match.sv
// Inclusive range comparator, one per directed window.
// Assumes lo and hi come from configuration registers.
`timescale 1ns/10ps
module range_match (
	input wire logic en,
	input wire logic [31:0] addr,
	input wire logic [31:0] lo,
	input wire logic [31:0] hi,
	output logic hit
);
	assign hit = en && (addr >= lo) && (addr <= hi);
endmodule

// ### logic/legacy_io_hole_address_decoder.sv
// Legacy compatibility hole and low I/O hole address decoder.
// Assumes one request a cycle from the processor bus front end.
// Overview of operation
// [RQ1] Write lock: BIOS range reads pass, writes drop
// [RQ2] Unlocked: BIOS range reads and writes to memory
// [RQ3] Controller never claims 768K to 1M; the decoder raises claim there, with target TGT_MEM or TGT_DROP
// [RQ4] Display enable bit gates display claim
// [RQ5] Display memory A0000-BFFFF, ports 3B0-3DF
// [RQ6] Display traffic goes to display route rope
// [RQ7] Aliases claimed ignoring upper six port bits
// [RQ8] Alias suppress bit stops alias forwarding
// [RQ9] Distributed window split into eight portions
// [RQ10] Two directed windows, each one rope
// [RQ11] Directed window beats distributed window
// [RQ12] Wide rope takes partner ropes' portions
// [RQ13] Configuration space beats low MMIO windows
// [RQ14] Guest config window 128K, 8K slices
// [RQ15] Interrupt message space not claimed
// [RQ16] Guest turns message writes into interrupts
// [RQ17] Guest peer access per forward bits
// [RQ18] Firmware space to hub or rope 0
// [RQ19] Without hub firmware requests 16 bytes max
// [RQ20] Unmatched hole addresses stay unclaimed
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "hole_decode_cfg.svh"
module legacy_io_hole_address_decoder
	import hole_decode_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire logic req_io,
	input wire logic req_write,
	input wire logic [31:0] req_addr,
	input wire logic [6:0] req_len,
	output logic claim,
	output target_t target,
	output logic [2:0] rope,
	output logic [3:0] guest_slice,
	output logic [31:0] fwd_addr
);
	logic bios_wp;
	logic disp_en;
	logic alias_sup;
	logic [2:0] disp_rope;
	logic [31:0] dist_lo;
	logic [31:0] dist_hi;
	logic [4:0] dist_lsb;
	logic [31:0] dir0_lo;
	logic [31:0] dir0_hi;
	logic [3:0] dir0_rope;
	logic [31:0] dir1_lo;
	logic [31:0] dir1_hi;
	logic [3:0] dir1_rope;
	logic [7:0] wide;
	logic [31:0] gcfg_base;
	logic gcfg_en;
	logic fw_hub;
	logic [31:0] rdata_mux;
	logic [7:0] claim_count;
	logic [7:0] drop_count;

	// Register writes
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bios_wp <= 1'b0;
			disp_en <= 1'b0;
			alias_sup <= 1'b0;
			disp_rope <= 3'h0;
			dist_lo <= 32'h0000_0000;
			dist_hi <= 32'h0000_0000;
			dist_lsb <= 5'h00;
			dir0_lo <= 32'h0000_0000;
			dir0_hi <= 32'h0000_0000;
			dir0_rope <= 4'h0;
			dir1_lo <= 32'h0000_0000;
			dir1_hi <= 32'h0000_0000;
			dir1_rope <= 4'h0;
			wide <= 8'h00;
			gcfg_base <= 32'h0000_0000;
			gcfg_en <= 1'b0;
			fw_hub <= 1'b0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`ADDR_A_BIOS_WP: bios_wp <= reg_wdata[0];
				`ADDR_A_DISP: begin
					disp_en <= reg_wdata[0];
					alias_sup <= reg_wdata[1];
					disp_rope <= reg_wdata[6:4];
				end
				`ADDR_A_DIST_LO: dist_lo <= reg_wdata;
				`ADDR_A_DIST_HI: dist_hi <= reg_wdata;
				`ADDR_A_DIST_LSB: dist_lsb <= reg_wdata[4:0];
				`ADDR_A_DIR0_LO: dir0_lo <= reg_wdata;
				`ADDR_A_DIR0_HI: dir0_hi <= reg_wdata;
				`ADDR_A_DIR0_ROPE: dir0_rope <= reg_wdata[3:0];
				`ADDR_A_DIR1_LO: dir1_lo <= reg_wdata;
				`ADDR_A_DIR1_HI: dir1_hi <= reg_wdata;
				`ADDR_A_DIR1_ROPE: dir1_rope <= reg_wdata[3:0];
				`ADDR_A_WIDE: wide <= reg_wdata[7:0];
				`ADDR_A_GCFG: begin
					gcfg_en <= reg_wdata[0];
					gcfg_base <= {reg_wdata[31:17], 17'h0_0000};
				end
				`ADDR_A_FWHUB: fw_hub <= reg_wdata[0];
				default: ;
			endcase
		end
	end

	// Read mux; bit 3 of a directed rope word is its enable
	assign rdata_mux =
		(reg_addr == `ADDR_A_BIOS_WP) ? {31'h0, bios_wp} :
		(reg_addr == `ADDR_A_DISP) ?
			{25'h0, disp_rope, 2'h0, alias_sup, disp_en} :
		(reg_addr == `ADDR_A_DIST_LO) ? dist_lo :
		(reg_addr == `ADDR_A_DIST_HI) ? dist_hi :
		(reg_addr == `ADDR_A_DIST_LSB) ? {27'h0, dist_lsb} :
		(reg_addr == `ADDR_A_DIR0_LO) ? dir0_lo :
		(reg_addr == `ADDR_A_DIR0_HI) ? dir0_hi :
		(reg_addr == `ADDR_A_DIR0_ROPE) ? {28'h0, dir0_rope} :
		(reg_addr == `ADDR_A_DIR1_LO) ? dir1_lo :
		(reg_addr == `ADDR_A_DIR1_HI) ? dir1_hi :
		(reg_addr == `ADDR_A_DIR1_ROPE) ? {28'h0, dir1_rope} :
		(reg_addr == `ADDR_A_WIDE) ? {24'h0, wide} :
		(reg_addr == `ADDR_A_GCFG) ? {gcfg_base[31:1], gcfg_en} :
		(reg_addr == `ADDR_A_FWHUB) ? {31'h0, fw_hub} :
		(reg_addr == `ADDR_A_STATUS) ?
			{16'h0, drop_count, claim_count} :
		32'h0000_0000;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rdata_mux : 32'h0000_0000;
		end
	end

	// Memory space windows
	wire is_mem = req_valid && !req_io;
	wire in_bios = is_mem && req_addr >= `BIOS_LO && req_addr <= `BIOS_HI;
	wire in_disp_mem = is_mem && req_addr >= `DISP_MEM_LO &&
		req_addr <= `DISP_MEM_HI;
	wire in_cfg = is_mem && req_addr >= `CFG_LO && req_addr <= `CFG_HI;
	wire in_intmsg = is_mem && req_addr >= `INTMSG_LO &&
		req_addr <= `INTMSG_HI;
	wire in_fw = is_mem && req_addr >= `FW_LO;
	// Base is 128K aligned; a bit match cannot wrap at the top of memory
	wire in_gcfg = is_mem && gcfg_en &&
		req_addr[31:17] == gcfg_base[31:17];
	wire [31:0] gcfg_off = req_addr - gcfg_base;

	// Display ports: low ten bits decoded, upper six ignored unless alias_sup is set
	wire is_io = req_valid && req_io;
	wire [9:0] port10 = req_addr[9:0];
	wire port_hit = port10 >= `DISP_IO_LO && port10 <= `DISP_IO_HI;
	wire port_base = req_addr[15:10] == 6'h00;
	wire disp_io = is_io && port_hit &&
		(port_base || !alias_sup); // [RQ7] [RQ8]

	// Directed and distributed low MMIO
	logic dir0_hit;
	logic dir1_hit;
	range_match u_dir0 (
		.en(is_mem && dir0_rope[3]),
		.addr(req_addr),
		.lo(dir0_lo),
		.hi(dir0_hi),
		.hit(dir0_hit)
	);
	range_match u_dir1 (
		.en(is_mem && dir1_rope[3]),
		.addr(req_addr),
		.lo(dir1_lo),
		.hi(dir1_hi),
		.hit(dir1_hit)
	);
	wire dist_hit = is_mem && dist_hi > dist_lo &&
		req_addr >= dist_lo && req_addr <= dist_hi;
	wire [31:0] dist_off = req_addr - dist_lo;
	wire [31:0] dist_sh = dist_off >> dist_lsb;
	wire [2:0] dist_raw = dist_sh[2:0]; // [RQ9]
	// Wide ropes: bit n set folds rope n onto its even partner
	wire [2:0] dist_rope = wide[dist_raw] ?
		{dist_raw[2:1], 1'b0} : dist_raw; // [RQ12]
	wire fw_ok = fw_hub || (req_len <= `FW_SMALL_MAX);

	// Priority decode, highest first
	target_t next_target;
	logic [2:0] next_rope;
	always_comb begin
		next_target = TGT_NONE; // [RQ20]
		next_rope = 3'h0;
		if (in_bios) begin
			// Writes swallowed while locked, still answered
			next_target = (req_write && bios_wp) ?
				TGT_DROP : TGT_MEM; // [RQ1] [RQ2] [RQ3]
		end else if (in_disp_mem || disp_io) begin
			if (disp_en) begin
				next_target = TGT_ROPE; // [RQ4] [RQ5]
				next_rope = disp_rope; // [RQ6]
			end
		end else if (in_cfg) begin
			next_target = TGT_CFG; // [RQ13]
		end else if (in_gcfg) begin
			next_target = TGT_GUEST_CFG; // [RQ14]
		end else if (in_intmsg) begin
			next_target = TGT_NONE; // [RQ15]
		end else if (in_fw) begin
			if (!fw_ok) begin
				next_target = TGT_REJECT; // [RQ19]
			end else if (fw_hub) begin
				next_target = TGT_FW_HUB; // [RQ18]
			end else begin
				next_target = TGT_ROPE;
				next_rope = 3'h0;
			end
		end else if (dir0_hit) begin
			next_target = TGT_ROPE; // [RQ10] [RQ11]
			next_rope = dir0_rope[2:0];
		end else if (dir1_hit) begin
			next_target = TGT_ROPE;
			next_rope = dir1_rope[2:0];
		end else if (dist_hit) begin
			next_target = TGT_ROPE;
			next_rope = dist_rope;
		end
	end

	wire next_claim = next_target != TGT_NONE;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			claim <= 1'b0;
			target <= TGT_NONE;
			rope <= 3'h0;
			guest_slice <= 4'h0;
			fwd_addr <= 32'h0000_0000;
		end else begin
			claim <= next_claim;
			target <= next_target;
			rope <= next_rope;
			guest_slice <= gcfg_off[`GUEST_SLICE_LSB+3:`GUEST_SLICE_LSB];
			fwd_addr <= req_addr; // [RQ7]
		end
	end

	// Statistics for software, saturating
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			claim_count <= 8'h00;
			drop_count <= 8'h00;
		end else begin
			if (next_claim && claim_count != 8'hFF)
				claim_count <= claim_count + 8'h01;
			if (next_target == TGT_DROP && drop_count != 8'hFF)
				drop_count <= drop_count + 8'h01;
		end
	end

	property p_bios_drop;
		@(posedge mclk) disable iff (sys_rst)
		(in_bios && req_write && bios_wp) |=> target == TGT_DROP;
	endproperty
	a_bios_drop: assert property (p_bios_drop) else $error("lock write"); // [RQ1]
	property p_bios_open;
		@(posedge mclk) disable iff (sys_rst)
		(in_bios && !bios_wp) |=> target == TGT_MEM;
	endproperty
	a_bios_open: assert property (p_bios_open) else $error("bios open"); // [RQ2]
	property p_disp_off;
		@(posedge mclk) disable iff (sys_rst)
		(in_disp_mem && !disp_en) |=> !claim;
	endproperty
	a_disp_off: assert property (p_disp_off) else $error("disp off"); // [RQ4]
	property p_disp_rope;
		@(posedge mclk) disable iff (sys_rst)
		(disp_io && disp_en) |=> (rope == $past(disp_rope));
	endproperty
	a_disp_rope: assert property (p_disp_rope) else $error("disp rope"); // [RQ6]
	property p_alias;
		@(posedge mclk) disable iff (sys_rst)
		(is_io && port_hit && !port_base && alias_sup) |=> !claim;
	endproperty
	a_alias: assert property (p_alias) else $error("alias leak"); // [RQ8]
	property p_cfg;
		@(posedge mclk) disable iff (sys_rst)
		(in_cfg && (dir0_hit || dir1_hit || dist_hit)) |=>
		target == TGT_CFG;
	endproperty
	a_cfg: assert property (p_cfg) else $error("cfg prio"); // [RQ13]
	property p_dir;
		@(posedge mclk) disable iff (sys_rst)
		(dir0_hit && dist_hit && !in_cfg && !in_gcfg && !in_fw &&
		!in_intmsg && !in_bios && !in_disp_mem) |=>
		rope == $past(dir0_rope[2:0]);
	endproperty
	a_dir: assert property (p_dir) else $error("dir prio"); // [RQ11]
	property p_intmsg;
		@(posedge mclk) disable iff (sys_rst)
		(in_intmsg && !in_gcfg) |=> !claim;
	endproperty
	a_intmsg: assert property (p_intmsg) else $error("intmsg"); // [RQ15]
	property p_fw;
		@(posedge mclk) disable iff (sys_rst)
		(in_fw && !in_gcfg && !fw_hub && req_len > `FW_SMALL_MAX) |=>
		target == TGT_REJECT;
	endproperty
	a_fw: assert property (p_fw) else $error("fw size"); // [RQ19]
	property p_bios_mem;
		@(posedge mclk) disable iff (sys_rst)
		in_bios |=> (target == TGT_MEM || target == TGT_DROP);
	endproperty
	a_bios_mem: assert property (p_bios_mem) else $error("bios rope"); // [RQ3]
	property p_fwd;
		@(posedge mclk) disable iff (sys_rst)
		req_valid |=> fwd_addr == $past(req_addr);
	endproperty
	a_fwd: assert property (p_fwd) else $error("fwd addr"); // [RQ7]
	property p_fw_hub;
		@(posedge mclk) disable iff (sys_rst)
		(in_fw && !in_gcfg && fw_hub) |=> target == TGT_FW_HUB;
	endproperty
	a_fw_hub: assert property (p_fw_hub) else $error("fw hub"); // [RQ18]
	property p_gcfg;
		@(posedge mclk) disable iff (sys_rst)
		(in_gcfg && !in_bios && !in_disp_mem && !in_cfg) |=>
		target == TGT_GUEST_CFG;
	endproperty
	a_gcfg: assert property (p_gcfg) else $error("guest cfg"); // [RQ14]
	property p_cv_disp;
		@(posedge mclk) disable iff (sys_rst)
		disp_io && disp_en;
	endproperty
	c_disp: cover property (p_cv_disp);
	property p_cv_dist;
		@(posedge mclk) disable iff (sys_rst)
		dist_hit && wide[dist_raw];
	endproperty
	c_dist: cover property (p_cv_dist);
	property p_cv_fw;
		@(posedge mclk) disable iff (sys_rst)
		in_fw && fw_hub;
	endproperty
	c_fw: cover property (p_cv_fw);
	property p_cv_dir;
		@(posedge mclk) disable iff (sys_rst)
		dir0_hit && dist_hit;
	endproperty
	c_dir: cover property (p_cv_dir);
endmodule

// ### testbench/rope_guest_model.sv
// Far-side rope guest sitting on one rope, counting what reaches it.
// Assumes it sees the decoder outputs in the cycle after each request.
`timescale 1ns/10ps
module rope_guest_model
	import hole_decode_pkg::*;
#(
	parameter logic [2:0] OWN_ROPE = 3'h5
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic claim,
	input wire target_t target,
	input wire logic [2:0] rope,
	input wire logic pci_valid,
	input wire logic pci_write,
	input wire logic pci_remote,
	input wire logic [31:0] pci_addr,
	input wire logic local_display_forward,
	input wire logic remote_display_peer_enable,
	output logic intr_out,
	output logic abort_out,
	output logic peer_ok,
	output logic [7:0] taken
);
	wire logic mine = claim && target == TGT_ROPE && rope == OWN_ROPE;
	wire logic intmsg = pci_valid && pci_addr >= 32'hFEE0_0000 &&
		pci_addr <= 32'hFEEF_FFFF;
	wire logic disp = pci_valid && pci_addr >= 32'h000A_0000 &&
		pci_addr <= 32'h000B_FFFF;
	assign intr_out = intmsg && pci_write;
	assign abort_out = intmsg && !pci_write;
	// Remote peers need the peer enable, local ones the forward bit
	assign peer_ok = disp && (pci_remote ?
		remote_display_peer_enable : local_display_forward);
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			taken <= 8'h00;
		end else if (mine) begin
			taken <= taken + 8'h01;
		end
	end
endmodule

// ### testbench/tb_legacy_io_hole_address_decoder.sv
// Self-checking bench for the hole decoder, random LOW_MMIO_WINDOW traffic.
// Assumes the cfg header and the package are compiled first.
`timescale 1ns/10ps
`include "hole_decode_cfg.svh"
module tb_legacy_io_hole_address_decoder;
	import hole_decode_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic req_valid = 1'b0;
	logic req_io = 1'b0;
	logic req_write = 1'b0;
	logic [31:0] req_addr = 32'h0000_0000;
	logic [6:0] req_len = 7'h00;
	logic [31:0] reg_rdata, fwd_addr, a;
	logic claim;
	target_t target;
	logic [2:0] rope;
	logic [3:0] guest_slice;
	logic [7:0] taken, wide;
	int n_errors = 0;
	int checks_done = 0;
	int n_rope5 = 0;
	logic pci_valid = 1'b0;
	logic pci_write = 1'b0;
	logic pci_remote = 1'b0;
	logic [31:0] pci_addr = 32'h0000_0000;
	logic lfwd = 1'b0;
	logic rpeer = 1'b0;
	logic intr_out, abort_out, peer_ok;
	always #4 mclk = ~mclk;
	legacy_io_hole_address_decoder uut (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
		.req_io(req_io), .req_write(req_write), .req_addr(req_addr),
		.req_len(req_len), .claim(claim), .target(target), .rope(rope),
		.guest_slice(guest_slice), .fwd_addr(fwd_addr));
	// Guest sees decoder traffic and PCI side requests from the bench
	rope_guest_model guest (.mclk(mclk), .sys_rst(sys_rst), .claim(claim),
		.target(target), .rope(rope), .pci_valid(pci_valid),
		.pci_write(pci_write), .pci_remote(pci_remote), .pci_addr(pci_addr),
		.local_display_forward(lfwd), .remote_display_peer_enable(rpeer),
		.intr_out(intr_out), .abort_out(abort_out), .peer_ok(peer_ok),
		.taken(taken));
	task automatic wrap_up();
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	// Idle cycle after each strobe keeps drivers single per step
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
		@(posedge mclk);
	endtask
	task automatic req(input logic io, input logic w, input logic [31:0] ad,
		input logic [6:0] ln, input target_t t, input logic [3:0] r);
		req_valid <= 1'b1;
		req_io <= io;
		req_write <= w;
		req_addr <= ad;
		req_len <= ln;
		@(posedge mclk);
		req_valid <= 1'b0;
		#1;
		check(claim, t != TGT_NONE);
		check(target, t);
		check(fwd_addr, ad);
		if (t == TGT_ROPE)
			check(rope, r[2:0]);
		if (t == TGT_GUEST_CFG)
			check(guest_slice, r);
		if (t == TGT_ROPE && r == 4'h5)
			n_rope5++;
		@(posedge mclk);
	endtask
	// Far side PCI request into the guest; its answers are combinational
	task automatic pci(input logic w, input logic rem, input logic [31:0] ad,
		input logic lf, input logic rp);
		pci_valid <= 1'b1;
		pci_write <= w;
		pci_remote <= rem;
		pci_addr <= ad;
		lfwd <= lf;
		rpeer <= rp;
		#1;
		check(intr_out, ad[31:20] == 12'hFEE && w);
		check(abort_out, ad[31:20] == 12'hFEE && !w);
		check(peer_ok, ad[31:17] == 15'h0005 && (rem ? rp : lf));
		@(posedge mclk);
	endtask
	function automatic logic [3:0] exp_dist(input logic [31:0] ad);
		logic [2:0] r;
		r = 3'((ad - 32'h8000_0000) >> 25);
		if (wide[r])
			r[0] = 1'b0;
		return {1'b0, r};
	endfunction
	initial begin
		#200000;
		n_errors++;
		wrap_up();
	end
	initial begin
		a = $urandom(81846);
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#1;
		check(target, TGT_NONE);
		check(claim, 1'b0);
		@(posedge mclk);
		rd(`ADDR_A_STATUS, 32'h0000_0000);
		rd(8'hFC, 32'h0000_0000);
		wr(`ADDR_A_BIOS_WP, 32'h0000_0001);
		req(0, 1, 32'h000C_0000, 7'h08, TGT_DROP, 0);
		rd(`ADDR_A_STATUS, 32'h0000_0101);
		req(0, 0, 32'h000F_FFF0, 7'h08, TGT_MEM, 0);
		wr(`ADDR_A_BIOS_WP, 32'h0000_0000);
		req(0, 1, 32'h000F_FFF0, 7'h08, TGT_MEM, 0);
		req(0, 0, 32'h000A_0000, 7'h04, TGT_NONE, 0);
		wr(`ADDR_A_DISP, 32'h0000_0051);
		req(0, 0, 32'h000A_0000, 7'h04, TGT_ROPE, 5);
		req(0, 1, 32'h000B_FFFC, 7'h04, TGT_ROPE, 5);
		req(1, 1, 32'h0000_03DF, 7'h01, TGT_ROPE, 5);
		req(1, 0, 32'h0000_03AF, 7'h01, TGT_NONE, 0);
		req(1, 0, 32'h0000_FFB0, 7'h01, TGT_ROPE, 5);
		req(0, 0, 32'h000C_0000, 7'h04, TGT_MEM, 0);
		wr(`ADDR_A_DISP, 32'h0000_0053);
		req(1, 0, 32'h0000_07D0, 7'h01, TGT_NONE, 0);
		req(1, 0, 32'h0000_03B0, 7'h01, TGT_ROPE, 5);
		wr(`ADDR_A_DIST_LO, 32'h8000_0000);
		wr(`ADDR_A_DIST_HI, 32'h8FFF_FFFF);
		wr(`ADDR_A_DIST_LSB, 32'h0000_0019);
		wr(`ADDR_A_DIR0_LO, 32'h8200_0000);
		wr(`ADDR_A_DIR0_HI, 32'h82FF_FFFF);
		wr(`ADDR_A_DIR0_ROPE, 32'h0000_000E);
		wr(`ADDR_A_DIR1_LO, 32'hFE00_0000);
		wr(`ADDR_A_DIR1_HI, 32'hFEEF_FFFF);
		wr(`ADDR_A_DIR1_ROPE, 32'h0000_000B);
		wr(`ADDR_A_GCFG, 32'h8E00_0001);
		wide = 8'($urandom) | 8'h02;
		wr(`ADDR_A_WIDE, {24'h00_0000, wide});
		rd(`ADDR_A_DIST_HI, 32'h8FFF_FFFF);
		rd(`ADDR_A_WIDE, {24'h00_0000, wide});
		repeat (200) begin
			a = 32'h8000_0000 | ($urandom & 32'h0FFF_FFFF);
			if (a[31:24] == 8'h82)
				req(0, 1, a, 7'h04, TGT_ROPE, 4'h6);
			else if (a[31:17] == 15'h4700)
				req(0, 1, a, 7'h04, TGT_GUEST_CFG, a[16:13]);
			else
				req(0, 1'($urandom), a, 7'h04, TGT_ROPE,
					exp_dist(a));
		end
		req(0, 0, 32'h8E00_A000, 7'h04, TGT_GUEST_CFG, 5);
		req(0, 0, 32'h8E01_FFFC, 7'h04, TGT_GUEST_CFG, 15);
		a = 32'h8E02_0000;
		req(0, 0, a, 7'h04, TGT_ROPE, exp_dist(a));
		req(0, 0, 32'h82FF_FFFC, 7'h04, TGT_ROPE, 6);
		a = 32'h8FFF_FFFC;
		req(0, 0, a, 7'h04, TGT_ROPE, exp_dist(a));
		req(0, 0, 32'h9000_0000, 7'h04, TGT_NONE, 0);
		req(0, 0, 32'hFE00_0000, 7'h04, TGT_ROPE, 3);
		req(0, 1, 32'hFED0_0000, 7'h04, TGT_CFG, 0);
		req(0, 1, 32'hFEE0_0000, 7'h04, TGT_NONE, 0);
		req(0, 0, 32'hFEF0_0000, 7'h04, TGT_NONE, 0);
		wr(`ADDR_A_FWHUB, 32'h0000_0001);
		req(0, 0, 32'hFF00_0000, 7'h40, TGT_FW_HUB, 0);
		wr(`ADDR_A_FWHUB, 32'h0000_0000);
		req(0, 0, 32'hFFFF_FFF0, 7'h10, TGT_ROPE, 0);
		req(0, 0, 32'hFFFF_FFF0, 7'h11, TGT_REJECT, 0);
		pci(1, 0, 32'hFEE0_0010, 1'b0, 1'b0);
		pci(0, 1, 32'hFEEF_FFF0, 1'b0, 1'b0);
		pci(0, 0, 32'h000A_0000, 1'b1, 1'b0);
		pci(0, 1, 32'h000B_FFF0, 1'b1, 1'b0);
		pci(1, 1, 32'h000A_8000, 1'b0, 1'b1);
		pci(1, 0, 32'h000B_0000, 1'b0, 1'b1);
		pci(0, 0, 32'h000C_0000, 1'b1, 1'b1);
		check(taken, 32'(8'(n_rope5)));
		wrap_up();
	end
endmodule
